/* File: testbench.sv */
// Self-checking bench for the timed I/O tile block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tip_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  tip_cmd_type op = CMD_NOP;
  logic [2:0] sel = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic link = 1'b0;
  logic [31:0] drv = 32'h0; // Level the application drives
  logic [4:0] stb = 5'h0;
  logic [31:0] pin; // Resolved pin levels
  logic [4:0] stb_in;
  logic done, ok;
  logic [31:0] rdata, pin_o, pin_oe;
  logic [4:0] evt, stb_out;
  int failures = 0;
  int compares = 0;
  tip_io_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .i_sel(sel), .i_cmd(op), .i_wdata(wdata), .i_link_en(link),
    .i_pin(pin), .i_strobe_in(stb_in), .o_done(done), .o_ok(ok),
    .o_rdata(rdata), .o_event(evt), .o_strobe_out(stb_out),
    .o_pin(pin_o), .o_pin_oe(pin_oe));
  tip_ext_model u_ext (.i_clk(clk), .i_dut_pin(pin_o), .i_dut_oe(pin_oe),
    .i_data(drv), .i_data_en(1'b1), .i_stb(stb), .o_wire(pin),
    .o_strobe_in(stb_in));
  // Free-running system clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One command, judged on its one-cycle answer
  task automatic run(input tip_cmd_type c, input logic [2:0] s,
                     input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    op <= c;
    sel <= s;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({31'h0, done}, 32'h1);
  endtask : run
  // Bounded wait for the event of one port
  task automatic wait_evt(input int p);
    int n;
    n = 0;
    while (evt[p] !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, evt[p]}, 32'h1);
  endtask : wait_evt
  task automatic t_counter();
    logic [31:0] a;
    @(posedge clk);
    req <= 1'b1;
    op <= CMD_GETC;
    sel <= 3'h0;
    @(posedge clk);
    #1;
    a = rdata;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk(rdata, a + 32'h1);
    run(CMD_GETC, 3'h0, 32'h0);
    a = rdata;
    run(CMD_GETC, 3'h0, 32'h0);
    chk(rdata, a + 32'h2);
  endtask : t_counter
  task automatic t_out32();
    logic [31:0] a;
    run(CMD_CFG, 3'h4, 32'h0000_000B);
    run(CMD_GETC, 3'h4, 32'h0);
    a = rdata;
    run(CMD_OUT, 3'h4, 32'hA5C3_1235);
    wait_evt(4);
    chk(pin_o, 32'hA5C3_1235);
    chk(pin_oe, 32'hFFFF_FFFF);
    chk({27'h0, stb_out}, 32'h10);
    run(CMD_GETTS, 3'h4, 32'h0);
    chk(rdata, a + 32'h3);
    // A timed transfer waits for its count and stamps exactly that
    run(CMD_SETT, 3'h4, a + 32'h10);
    run(CMD_OUT, 3'h4, 32'hA5C3_1235);
    wait_evt(4);
    run(CMD_GETTS, 3'h4, 32'h0);
    chk(rdata, a + 32'h10);
  endtask : t_out32
  task automatic t_oc_link();
    run(CMD_CFG, 3'h0, 32'h7);
    run(CMD_OUT, 3'h0, 32'hFFFF_FFFE);
    wait_evt(0);
    chk(pin_o, 32'hA5C3_1234);
    chk(pin_oe, 32'hFFFF_FFFF);
    @(posedge clk);
    #1;
    chk(pin_oe, 32'hFFFF_FFFE);
    @(posedge clk);
    link <= 1'b1;
    #1;
    chk(pin_oe, 32'hFFFF_0FFE);
    repeat (2) @(posedge clk);
    link <= 1'b0;
  endtask : t_oc_link
  task automatic t_input();
    logic [7:0] b [6] = '{8'h11, 8'h22, 8'h3C, 8'h4D, 8'h5E, 8'h6F};
    logic [31:0] nev;
    nev = 32'h0;
    run(CMD_CFG, 3'h0, 32'h0);
    run(CMD_CFG, 3'h2, 32'h89);
    run(CMD_SETC, 3'h2, 32'h3C);
    chk(pin_oe, 32'hFFFF_FF00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      drv <= (i < 6) ? {24'h0, b[i]} : 32'h0;
      stb <= (i < 6) ? 5'h04 : 5'h00;
      #1;
      nev += evt[2];
    end
    chk(nev, 32'h2);
    run(CMD_IN, 3'h2, 32'h0);
    chk(rdata, 32'h6F5E_4D3C);
    run(CMD_IN, 3'h2, 32'h0);
    chk({31'h0, ok}, 32'h0);
    // Not-equal condition: the matching level is passed over
    run(CMD_CFG, 3'h2, 32'h109);
    @(posedge clk);
    drv <= 32'h3C;
    stb <= 5'h04;
    @(posedge clk);
    #1;
    chk({27'h0, evt}, 32'h0);
    @(posedge clk);
    drv <= 32'h55;
    #1;
    wait_evt(2);
    @(posedge clk);
    drv <= 32'h0;
    stb <= 5'h00;
  endtask : t_input
  task automatic t_refuse();
    tip_cmd_type c [5] = '{CMD_NOP, CMD_OUT, CMD_CLK, CMD_CLK, CMD_IN};
    logic [2:0] s [5] = '{3'h0, 3'h5, 3'h0, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++) begin
      run(c[i], s[i], 32'h0);
      chk({31'h0, ok}, 32'h0);
    end
  endtask : t_refuse
  task automatic t_clkblk();
    logic [31:0] a;
    run(CMD_CLK, 3'h1, 32'h3);
    chk({31'h0, ok}, 32'h1);
    run(CMD_CFG, 3'h3, 32'h13);
    run(CMD_GETC, 3'h3, 32'h0);
    a = rdata;
    repeat (38) @(posedge clk);
    run(CMD_GETC, 3'h3, 32'h0);
    chk(rdata, a + 32'hA);
    run(CMD_CLK, 3'h2, 32'h101);
    run(CMD_CFG, 3'h1, 32'h21);
    run(CMD_GETC, 3'h1, 32'h0);
    a = rdata;
    repeat (10) begin
      @(posedge clk);
      drv <= 32'h1;
      repeat (2) @(posedge clk);
      drv <= 32'h0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    run(CMD_GETC, 3'h1, 32'h0);
    chk(rdata, a + 32'h5);
  endtask : t_clkblk
  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pin_oe, 32'h0);
    t_counter();
    t_out32();
    t_oc_link();
    t_input();
    t_refuse();
    t_clkblk();
    end_of_test();
  end
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : testbench

/* File: tip_clk_if.sv */
// Link between the tile core logic and one clock block
interface tip_clk_if;
  import tip_pkg::*;
  logic [DIV_W-1:0] div;   // Divide by div+1
  logic ext;               // Source is the 1-bit port pin
  logic src_pin;           // Level of the 1-bit port pin
  logic tick;              // One-cycle pulse per clock block edge
  modport blk (input div, input ext, input src_pin, output tick);
  modport ctl (output div, output ext, output src_pin, input tick);
endinterface : tip_clk_if

/* File: tip_clkblk.sv */
// One programmable clock block producing port clock ticks
module tip_clkblk #(
  parameter bit IS_REF = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  tip_clk_if.blk cb
);
  import tip_pkg::*;

  // Block state
  typedef struct packed {
    logic [DIV_W-1:0] cnt;   // Divider count
    logic prev;              // Last pin level for edge detect
    logic tick;              // Registered tick
  } tip_cb_st_type;

  tip_cb_st_type q, d;

  // Next state: divide either the system clock or pin rising edges
  always_comb begin
    logic edge_seen;
    edge_seen = 1'b0;
    d = q;
    d.prev = cb.src_pin;
    d.tick = 1'b0;
    if (IS_REF) begin
      // Reference block ticks at the full reference rate
      d.tick = (REF_DIV_CYCLES == 1) || (q.cnt == '0);
    end else begin
      // External pin edges or system clock as source
      edge_seen = cb.ext ? (cb.src_pin && !q.prev) : 1'b1;
      if (edge_seen) begin
        if (q.cnt >= cb.div) begin
          d.cnt = '0;
          d.tick = 1'b1;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cb.tick = q.tick;
endmodule : tip_clkblk

/* File: tip_ext_model.sv */
// Application hardware on the pins: resolves pin levels and strobes
module tip_ext_model (
  input wire logic i_clk,
  input wire logic [tip_pkg::PIN_W-1:0] i_dut_pin,
  input wire logic [tip_pkg::PIN_W-1:0] i_dut_oe,
  input wire logic [tip_pkg::PIN_W-1:0] i_data,
  input wire logic i_data_en,
  input wire logic [tip_pkg::NUM_PORTS-1:0] i_stb,
  output logic [tip_pkg::PIN_W-1:0] o_wire,
  output logic [tip_pkg::NUM_PORTS-1:0] o_strobe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import tip_pkg::*;
  logic [PIN_W-1:0] pat_q = '0; // Floating lines flip every cycle
  // No pull on these lines, so a floating pin never looks settled
  always @(posedge i_clk) begin
    pat_q <= ~o_wire;
  end
  // Device drive wins; otherwise our data or the floating pattern
  assign o_wire = (i_dut_oe & i_dut_pin) |
    (~i_dut_oe & (i_data_en ? i_data : pat_q));
  // Strobe only travels together with our data
  assign o_strobe_in = i_data_en ? i_stb : '0;
endmodule : tip_ext_model

/* File: tip_io_monitor.sv */
// Concurrent checks on the ports of the timed I/O tile block
module tip_io_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [tip_pkg::SEL_W-1:0] i_sel,
  input wire tip_pkg::tip_cmd_type i_cmd,
  input wire logic [tip_pkg::PIN_W-1:0] i_wdata,
  input wire logic i_link_en,
  input wire logic o_done,
  input wire logic o_ok,
  input wire logic [tip_pkg::PIN_W-1:0] o_rdata,
  input wire logic [tip_pkg::NUM_PORTS-1:0] o_event,
  input wire logic [tip_pkg::PIN_W-1:0] o_pin,
  input wire logic [tip_pkg::PIN_W-1:0] o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import tip_pkg::*;
  logic oc0_q; // Port 0 set up as open-collector output
  logic blk0_q; // Port 0 counts on clock block 0
  // Shadow of port 0 setup; out-of-range block numbers fall back to 0
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      oc0_q <= 1'b0;
      blk0_q <= 1'b1;
    end else if (i_req && i_cmd == CMD_CFG && i_sel == 3'h0) begin
      oc0_q <= i_wdata[0] & i_wdata[1] & i_wdata[2];
      blk0_q <= (i_wdata[6:4] == 3'h0) || (i_wdata[6:4] >= 3'h6);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A counter read on port 0
  sequence s_getc0;
    i_req && i_cmd == CMD_GETC && i_sel == 3'h0;
  endsequence
  a_done_after_req: assert property (i_req |=> o_done)
    else $error("no answer one cycle after a request");
  a_no_stray_done: assert property (!i_req |=> !o_done)
    else $error("answer without a request");
  a_ok_with_done: assert property (o_ok |-> o_done)
    else $error("accept flag outside an answer");
  a_reset_quiet: assert property ($rose(i_rst_n) |->
    o_pin_oe == '0 && o_event == '0)
    else $error("pins or events active after reset");
  a_oc_low_only: assert property (oc0_q && o_pin_oe[0] |-> !o_pin[0])
    else $error("open-collector pin driven high");
  a_link_pins_off: assert property (i_link_en && $past(i_link_en) |->
    (o_pin_oe & LINK_PIN_MASK) == '0)
    else $error("port drives a link pin");
  a_undriven_low: assert property ((o_pin & ~o_pin_oe) == '0)
    else $error("undriven pin shows a high value");
  a_bad_cmd_refused: assert property (i_req && (i_cmd == CMD_NOP ||
    (i_cmd != CMD_CLK && i_sel > 3'h4)) |=> o_done && !o_ok)
    else $error("invalid command accepted");
  a_count_steps: assert property (blk0_q throughout (s_getc0 ##1 s_getc0)
    |=> o_rdata[15:0] == $past(o_rdata[15:0]) + 16'h1)
    else $error("port counter did not advance by one");
endmodule : tip_io_monitor

bind tip_io_top tip_io_monitor u_mon (.i_clk, .i_rst_n, .i_req, .i_sel,
  .i_cmd, .i_wdata, .i_link_en, .o_done, .o_ok, .o_rdata, .o_event,
  .o_pin, .o_pin_oe);

/* File: tip_io_top.sv */
// Timed I/O ports of one tile with their clock blocks
//
// Contract
// - Ports of 1, 4, 8, 16, 32 bits
// - All pins of a port share direction
// - Drive pins or sample, optionally on condition
// - Each port access completes in one cycle
// - Open collector: low for zero, float one
// - Serdes plus transfer register between pins, core
// - 16-bit counter schedules each transfer
// - Counter readable; timed transfers wait for it
// - Counter captured as timestamp per transfer
// - Enabled link disables ports on its pins
// - Narrower enabled port beats wider on pins
// - Unshared pins stay with the wider port
// - Ports always transfer at nominal width
// - Six clock blocks; block 0 is reference
// - Other clock blocks run at own rate
// - Clock block may divide 1-bit port pin
// - Strobe in accepted, strobe out generated
// - After reset all ports use block 0
// - Port activity raises event to core
module tip_io_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [tip_pkg::SEL_W-1:0] i_sel,
  input wire tip_pkg::tip_cmd_type i_cmd,
  input wire logic [tip_pkg::PIN_W-1:0] i_wdata,
  input wire logic i_link_en,
  input wire logic [tip_pkg::PIN_W-1:0] i_pin,
  input wire logic [tip_pkg::NUM_PORTS-1:0] i_strobe_in,
  output logic o_done,
  output logic o_ok,
  output logic [tip_pkg::PIN_W-1:0] o_rdata,
  output logic [tip_pkg::NUM_PORTS-1:0] o_event,
  output logic [tip_pkg::NUM_PORTS-1:0] o_strobe_out,
  output logic [tip_pkg::PIN_W-1:0] o_pin,
  output logic [tip_pkg::PIN_W-1:0] o_pin_oe
);
  import tip_pkg::*;

  localparam int NP = NUM_PORTS;
  localparam int NCB = NUM_CLKBLK;

  // Whole state of the tile ports
  typedef struct packed {
    logic [NP-1:0] en;                  // Port enabled
    logic [NP-1:0] dout;                // Port is an output
    logic [NP-1:0] oc;                  // Open collector drive
    logic [NP-1:0] stb;                 // Strobe handshake in use
    logic [NP-1:0] timed;               // Transfer waits for count
    logic [NP-1:0] full;                // Transfer register holds data
    logic [NP-1:0] ev;                  // Event pulse to the core
    logic [NP-1:0] sbo;                 // Strobe out pulse
    logic [NP-1:0] sd;                  // Serdes state, tip_sd_type
    logic [NP-1:0][SEL_W-1:0] csel;     // Clock block feeding the port
    logic [NP-1:0][1:0] cond;           // Pin condition, tip_cond_type
    logic [NP-1:0][CNT_W-1:0] cnt;      // Port counter
    logic [NP-1:0][CNT_W-1:0] tm;       // Count a timed transfer waits for
    logic [NP-1:0][CNT_W-1:0] ts;       // Timestamp of last transfer
    logic [NP-1:0][PIN_W-1:0] xfer;     // Transfer register
    logic [NP-1:0][PIN_W-1:0] sh;       // Serdes shift register
    logic [NP-1:0][PIN_W-1:0] cdat;     // Condition compare value
    logic [NP-1:0][PIN_W-1:0] pout;     // Value held on output pins
    logic [NP-1:0][NSH_W-1:0] nsh;      // Words left or gathered
    logic [NCB-1:0][DIV_W-1:0] div;     // Clock block dividers
    logic [NCB-1:0] ext;                // Clock block pin source
    logic [PIN_W-1:0] rdata;            // Answer data
    logic done;                         // Answer strobe
    logic ok;                           // Answer success
  } tip_top_st_type;

  tip_top_st_type q, d;
  logic [NCB-1:0] blk_tick;             // Tick of each clock block

  // Clock blocks; block 0 is fixed to the reference clock
  tip_clk_if cb_if [NCB] ();
  genvar g;
  generate
    for (g = 0; g < NCB; g++) begin : g_cb
      // Configuration reaches the block through its interface
      assign cb_if[g].div = q.div[g];
      assign cb_if[g].ext = q.ext[g];
      // The 1-bit port pin is the external clock source
      assign cb_if[g].src_pin = i_pin[0];
      assign blk_tick[g] = cb_if[g].tick;
      tip_clkblk #(
        .IS_REF(g == REF_CLKBLK)
      ) u_cb (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .cb(cb_if[g])
      );
    end
  endgenerate

  // Next state: core commands first, then port hardware
  always_comb begin
    logic tk;                           // Port clock tick this cycle
    logic cond_ok;                      // Pin condition satisfied
    logic time_ok;                      // Timed wait satisfied
    logic stb_ok;                       // Strobe in present if needed
    logic [PIN_W-1:0] src;              // Word being shifted out
    logic [PIN_W-1:0] shin;             // Shift register after input
    logic [NSH_W-1:0] left;             // Words left to shift out
    logic [NSH_W-1:0] got;              // Words gathered so far
    logic [PIN_W-1:0] pinv;             // Pins seen by the port
    logic sett_hit;                     // Timed wait armed this cycle
    tk = 1'b0;
    cond_ok = 1'b0;
    time_ok = 1'b0;
    stb_ok = 1'b0;
    src = '0;
    shin = '0;
    left = '0;
    got = '0;
    pinv = '0;
    sett_hit = 1'b0;
    d = q;
    d.done = 1'b0;
    d.ok = 1'b0;
    d.ev = '0;
    d.sbo = '0;

    // One access per cycle, answered at the next edge
    if (i_req) begin
      d.done = 1'b1;
      if (i_cmd == CMD_CLK) begin
        // Clock block rate and source; block 0 stays fixed
        if (i_sel < NCB && i_sel != REF_CLKBLK) begin
          d.div[i_sel] = i_wdata[CLKCFG_DIV_LSB +: DIV_W];
          d.ext[i_sel] = i_wdata[CLKCFG_EXT_BIT];
          d.ok = 1'b1;
        end
      end else if (i_sel < NP) begin
        case (i_cmd)
          CMD_CFG: begin
            // Direction is one bit for the whole port
            d.en[i_sel] = i_wdata[CFG_EN_BIT];
            d.dout[i_sel] = i_wdata[CFG_OUT_BIT];
            d.oc[i_sel] = i_wdata[CFG_OC_BIT];
            d.stb[i_sel] = i_wdata[CFG_STB_BIT];
            d.cond[i_sel] = i_wdata[CFG_COND_LSB +: 2];
            // Out of range block numbers fall back to block 0
            if (i_wdata[CFG_CLK_LSB +: SEL_W] < NCB) begin
              d.csel[i_sel] = i_wdata[CFG_CLK_LSB +: SEL_W];
            end else begin
              d.csel[i_sel] = RST_CLKSEL;
            end
            // Reconfiguring drops half-moved data unless the port moves it on in the same cycle
            d.full[i_sel] = 1'b0;
            d.timed[i_sel] = 1'b0;
            d.nsh[i_sel] = '0;
            d.sd[i_sel] = SD_IDLE;
            d.ok = 1'b1;
          end
          CMD_OUT: begin
            // Core fills the transfer register when it is empty
            if (q.en[i_sel] && q.dout[i_sel] && !q.full[i_sel]) begin
              d.xfer[i_sel] = i_wdata;
              d.full[i_sel] = 1'b1;
              d.ok = 1'b1;
            end
          end
          CMD_IN: begin
            // Core empties the transfer register when it is full
            if (q.en[i_sel] && !q.dout[i_sel] && q.full[i_sel]) begin
              d.rdata = q.xfer[i_sel];
              d.full[i_sel] = 1'b0;
              d.ok = 1'b1;
            end
          end
          CMD_SETT: begin
            // Hold the next transfer until this count
            d.tm[i_sel] = i_wdata[CNT_W-1:0];
            d.timed[i_sel] = 1'b1;
            d.ok = 1'b1;
          end
          CMD_SETC: begin
            d.cdat[i_sel] = i_wdata;
            d.ok = 1'b1;
          end
          CMD_GETC: begin
            // Counter is readable at any time
            d.rdata = {{(PIN_W-CNT_W){1'b0}}, q.cnt[i_sel]};
            d.ok = 1'b1;
          end
          CMD_GETTS: begin
            d.rdata = {{(PIN_W-CNT_W){1'b0}}, q.ts[i_sel]};
            d.ok = 1'b1;
          end
          default: begin
            d.ok = 1'b0;
          end
        endcase
      end
    end

    // Port hardware, one pass per port
    for (int p = 0; p < NP; p++) begin
      tk = blk_tick[q.csel[p]];
      pinv = i_pin & PORT_MASK[p];
      time_ok = !q.timed[p] || (q.cnt[p] == q.tm[p]);
      stb_ok = !q.stb[p] || i_strobe_in[p];
      case (tip_cond_type'(q.cond[p]))
        COND_EQ: cond_ok = (pinv == (q.cdat[p] & PORT_MASK[p]));
        COND_NEQ: cond_ok = (pinv != (q.cdat[p] & PORT_MASK[p]));
        default: cond_ok = 1'b1;
      endcase
      left = q.nsh[p];
      src = q.sh[p];
      // A timed wait armed in the same cycle as a transfer is kept
      // for the next transfer: the arming beats the clear
      sett_hit = i_req && (i_cmd == CMD_SETT) && (i_sel == SEL_W'(p));

      // Counter steps on each tick of the chosen block
      if (tk) begin
        d.cnt[p] = q.cnt[p] + 1'b1;
      end

      if (q.en[p] && q.dout[p] && tk) begin
        // Output: start a word when due, else keep shifting
        if (q.sd[p] == SD_IDLE && q.full[p] && time_ok) begin
          src = q.xfer[p];
          left = XFER_TICKS[p];
          d.full[p] = 1'b0;
          if (!sett_hit) begin
            d.timed[p] = 1'b0;
          end
          d.ts[p] = q.cnt[p];
          d.ev[p] = 1'b1;
        end
        if (left != '0) begin
          // Full word leaves in nominal-width slices
          d.pout[p] = src & PORT_MASK[p];
          d.sh[p] = src >> PORT_WIDTH[p];
          d.nsh[p] = left - 1'b1;
          d.sd[p] = (left == 1) ? SD_IDLE : SD_SHIFT;
          d.sbo[p] = q.stb[p];
        end
      end else if (q.en[p] && !q.dout[p] && tk) begin
        // Input: sample when strobe, condition and time agree
        if (stb_ok && cond_ok && time_ok) begin
          shin = (q.sh[p] >> PORT_WIDTH[p])
               | (pinv << (PIN_W - PORT_WIDTH[p]));
          got = q.nsh[p] + 1'b1;
          d.sh[p] = shin;
          if (!sett_hit) begin
            d.timed[p] = 1'b0;
          end
          // A met condition fires once, then sampling is free
          d.cond[p] = COND_NONE;
          if (q.cond[p] != COND_NONE) begin
            d.ev[p] = 1'b1;
          end
          if (got == XFER_TICKS[p]) begin
            // Word complete: hand to transfer register
            d.xfer[p] = shin;
            d.full[p] = 1'b1;             // Set wins over a read
            d.ts[p] = q.cnt[p];
            d.ev[p] = 1'b1;
            d.nsh[p] = '0;
            d.sd[p] = SD_IDLE;
          end else begin
            d.nsh[p] = got;
            d.sd[p] = SD_SHIFT;
          end
        end
      end
    end
  end

  // Synchronous reset clears every field, the block selects included
  // State register; reset puts every port on block 0
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Pin drive is combinational from registered state and i_link_en, so the link
  // takes its pins back in the very cycle it is enabled
  // Pins shared by width precedence and the link
  tip_pinmux u_mux (
    .i_en(q.en),
    .i_dout(q.dout),
    .i_oc(q.oc),
    .i_link_en(i_link_en),
    .i_val(q.pout),
    .o_pin(o_pin),
    .o_pin_oe(o_pin_oe)
  );

  // Registered answers and pulses
  assign o_done = q.done;
  assign o_ok = q.ok;
  assign o_rdata = q.rdata;
  assign o_event = q.ev;
  assign o_strobe_out = q.sbo;
endmodule : tip_io_top

/* File: tip_pinmux.sv */
// Pin sharing between ports of different widths and the link
module tip_pinmux (
  input wire logic [tip_pkg::NUM_PORTS-1:0] i_en,
  input wire logic [tip_pkg::NUM_PORTS-1:0] i_dout,
  input wire logic [tip_pkg::NUM_PORTS-1:0] i_oc,
  input wire logic i_link_en,
  input wire logic [tip_pkg::NUM_PORTS-1:0][tip_pkg::PIN_W-1:0] i_val,
  output logic [tip_pkg::PIN_W-1:0] o_pin,
  output logic [tip_pkg::PIN_W-1:0] o_pin_oe
);
  import tip_pkg::*;

  // Each pin goes to the narrowest enabled port that covers it
  always_comb begin
    logic taken;
    taken = 1'b0;
    o_pin = '0;
    o_pin_oe = '0;
    for (int b = 0; b < PIN_W; b++) begin
      // Link pins are lost to every port while the link runs
      taken = i_link_en && LINK_PIN_MASK[b];
      for (int p = 0; p < NUM_PORTS; p++) begin
        // Narrow first, so a narrower port wins the pin
        // Uncovered pins fall through to wider ports
        if (!taken && i_en[p] && PORT_MASK[p][b]) begin
          taken = 1'b1;
          if (i_dout[p]) begin
            // Whole port drives one way; inputs never drive
            if (i_oc[p]) begin
              // Pull low for zero, float for one
              o_pin[b] = 1'b0;
              o_pin_oe[b] = !i_val[p][b];
            end else begin
              o_pin[b] = i_val[p][b];
              o_pin_oe[b] = 1'b1;
            end
          end
        end
      end
    end
  end
endmodule : tip_pinmux

/* File: tip_pkg.sv */
// Shared constants and types for the timed I/O port tile block
package tip_pkg;
  localparam int NUM_PORTS = 5;          // Ports of 1, 4, 8, 16, 32 bits
  localparam int NUM_CLKBLK = 6;         // Clock blocks per tile
  localparam int PIN_W = 32;             // Physical pins of the tile
  localparam int CNT_W = 16;             // Port counter width
  localparam int DIV_W = 8;              // Clock block divider width
  localparam int SEL_W = 3;              // Port / clock block index width
  localparam int NSH_W = 6;              // Serdes word counter width
  // Port widths, narrowest first; order sets pin precedence
  localparam int PORT_WIDTH [NUM_PORTS] = '{1, 4, 8, 16, 32};
  // Pins covered by each port, all starting at pin 0
  localparam logic [PIN_W-1:0] PORT_MASK [NUM_PORTS] = '{
    32'h0000_0001, 32'h0000_000F, 32'h0000_00FF,
    32'h0000_FFFF, 32'hFFFF_FFFF};
  // Port clock ticks per 32-bit transfer word
  localparam logic [NSH_W-1:0] XFER_TICKS [NUM_PORTS] = '{
    6'h20, 6'h08, 6'h04, 6'h02, 6'h01};
  // Pins handed to the inter-chip link when it is enabled
  localparam logic [PIN_W-1:0] LINK_PIN_MASK = 32'h0000_F000;
  // Reference clock and system clock rates
  localparam int SYS_CLK_MHZ = 100;
  localparam int REF_CLK_MHZ = 100;
  localparam int REF_DIV_CYCLES = SYS_CLK_MHZ / REF_CLK_MHZ;
  // Clock block every port uses after reset
  localparam logic [SEL_W-1:0] RST_CLKSEL = 3'h0;
  localparam logic [SEL_W-1:0] REF_CLKBLK = 3'h0;
  // Port configuration word fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_OUT_BIT = 1;
  localparam int CFG_OC_BIT = 2;
  localparam int CFG_STB_BIT = 3;
  localparam int CFG_CLK_LSB = 4;
  localparam int CFG_COND_LSB = 7;
  // Clock block configuration word fields
  localparam int CLKCFG_DIV_LSB = 0;
  localparam int CLKCFG_EXT_BIT = 8;
  // Core access commands
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_CFG = 4'h1, CMD_OUT = 4'h2, CMD_IN = 4'h3,
    CMD_SETT = 4'h4, CMD_SETC = 4'h5, CMD_GETC = 4'h6,
    CMD_GETTS = 4'h7, CMD_CLK = 4'h8
  } tip_cmd_type;
  // Input pin conditions
  typedef enum logic [1:0] {
    COND_NONE = 2'b00, COND_EQ = 2'b01, COND_NEQ = 2'b10
  } tip_cond_type;
  // Serdes activity of a port
  typedef enum logic [0:0] {
    SD_IDLE = 1'b0, SD_SHIFT = 1'b1
  } tip_sd_type;
endpackage : tip_pkg
